// ==== verilog/synth_latch_consts.svh ====
// Constants of the synthesizer serial programming bank: field positions,
// address codes and reset values.
// Assumes inclusion by its bare name from the package or the design file.
`ifndef SYNTH_LATCH_CONSTS_SVH
`define SYNTH_LATCH_CONSTS_SVH

`define WORD_BITS            24
`define ADDR_LO_POS          0
`define ADDR_HI_POS          1
`define ADDR_CONTROL         2'h0
`define ADDR_REFERENCE       2'h1
`define ADDR_FEEDBACK        2'h2
`define ADDR_TEST            2'h3

// Control latch fields.
`define CTL_RESET_POS        4
`define CTL_POLARITY_POS     8
`define CTL_TRISTATE_POS     9
`define CTL_GAIN_POS         10
`define CTL_MUTE_POS         11
`define CTL_CUR_LO_POS       14
`define CTL_CUR_HI_POS       17
`define CTL_OUT_PWR_POS      12
`define CTL_CORE_PWR_POS     5

// Feedback divider latch fields.
`define FB_SWALLOW_POS       2
`define FB_MAIN_POS          8
`define FB_GAIN_POS          21
`define FB_HALVE_POS         22
`define FB_HALVED_SRC_POS    23

// Reference divider latch fields.
`define REF_DIV_POS          2
`define REF_BACKLASH_POS     16
`define REF_PRECISION_POS    18
`define REF_TEST_POS         19
`define REF_BAND_DIV_POS     20

// Lock counts for the two precision settings.
`define LOCK_COUNT_FINE      3'h5
`define LOCK_COUNT_COARSE    3'h3

// Reset values of the stored latches.
`define CONTROL_RESET        24'h000010
`define FEEDBACK_RESET       24'h000C02
`define REFERENCE_RESET      24'h000005

`endif

// ==== verilog/synth_latch_pkg.sv ====
// Types shared by the synthesizer serial programming bank.
// Assumes the constants header is on the include path.
package synth_latch_pkg;

    // Decoded control latch settings.
    typedef struct packed {
        logic [2:0] pump_current_lo;
        logic [2:0] pump_current_hi;
        logic [1:0] out_power;
        logic [1:0] core_power;
        logic       mute_until_lock;
        logic       pump_tristate;
        logic       detector_polarity;
        logic       counter_reset;
    } loop_cfg_t;

    // Decoded feedback divider latch settings.
    typedef struct packed {
        logic [4:0]  swallow_count;
        logic [12:0] main_count;
        logic        output_halve_en;
        logic        halved_prescaler_src;
    } feedback_cfg_t;

    // Decoded reference divider latch settings.
    typedef struct packed {
        logic [13:0] ref_div;
        logic [1:0]  backlash_width;
        logic        lock_precision;
        logic        factory_test_bit;
        logic [1:0]  band_clk_div;
    } reference_cfg_t;

    // Serial front end states.
    typedef enum logic [0:0] {
        LINK_IDLE,
        LINK_SHIFT
    } link_state_t;

endpackage

// ==== verilog/synth_serial_latch_bank.sv ====
// Serial programming bank of an integer-N synthesizer: a three-wire shift
// port fills one of four 24-bit latches, whose decoded settings leave here.
// Assumes SCLK, DATA and the load strobe are asynchronous pins well below
// a quarter of SYS_CLK_IN, and that lock and reference tick come from logic
// on SYS_CLK_IN.
//
// Operation
// - Pump currents come from low and high fields.
// - Control latch holds output and core power.
// - Mute bit blanks RF outputs until lock.
// - Gain bit picks current setting two or one.
// - Tristate bit floats the charge pump.
// - Polarity bit: one positive, zero negative.
// - Counter reset bit holds all dividers reset.
// - Feedback latch carries five-bit swallow count.
// - Feedback latch carries thirteen-bit main count.
// - Total division is modulus times main plus swallow.
// - One gain bit, latest write from either latch.
// - Feedback bit 22 enables output halving.
// - Feedback bit 23 feeds halved signal to prescaler.
// - Address zero-one loads the reference latch.
// - Reference latch carries fourteen-bit divide ratio.
// - Reference bits 16 and 17 set backlash width.
// - Lock after five or three good cycles.
// - Test bit zero ignores test latch.
// - Band clock divider slows band-select clock.
// - Shift on serial clock rise, load on strobe.
// - Address zero-zero loads the control latch.
// - Shifting and loading continue while powered down.
`include "synth_latch_consts.svh"

module synth_serial_latch_bank #(
    parameter int PRESCALER_MOD = 8
) (
    input  wire logic                          SYS_CLK_IN,
    input  wire logic                          ARST_N_IN,
    input  wire logic                          SCLK_IN,
    input  wire logic                          SDATA_IN,
    input  wire logic                          LOAD_STROBE_IN,
    input  wire logic                          PFD_GOOD_IN,
    input  wire logic                          REF_TICK_IN,
    output logic                               RF_ENABLE_OUT,
    output logic                               LOCKED_OUT,
    output logic [2:0]                         PUMP_CURRENT_OUT,
    output logic                               PUMP_TRISTATE_OUT,
    output logic                               PUMP_GAIN_SEL_OUT,
    output logic                               COUNTER_RESET_OUT,
    output logic                               BAND_CLK_OUT,
    output logic                               TEST_MODE_OUT,
    output logic [18:0]                        TOTAL_DIVIDE_OUT,
    output synth_latch_pkg::loop_cfg_t         LOOP_CFG_OUT,
    output synth_latch_pkg::feedback_cfg_t     FEEDBACK_CFG_OUT,
    output synth_latch_pkg::reference_cfg_t    REFERENCE_CFG_OUT
);

    logic [2:0]                    sclk_sync_q;
    logic [1:0]                    sdata_sync_q;
    logic [2:0]                    strobe_sync_q;
    logic                          sclk_rise;
    logic                          strobe_rise;
    logic                          load_now;
    logic [`WORD_BITS-1:0]         shift_q;
    logic [1:0]                    addr;
    synth_latch_pkg::link_state_t  link_state_q;
    logic [`WORD_BITS-1:0]         control_q;
    logic [`WORD_BITS-1:0]         feedback_q;
    logic [`WORD_BITS-1:0]         reference_q;
    logic [`WORD_BITS-1:0]         test_q;
    logic                          gain_q;
    logic [2:0]                    good_count_q;
    logic [2:0]                    lock_target;
    logic                          locked_q;
    logic [2:0]                    band_count_q;
    logic                          band_clk_q;
    logic [2:0]                    band_limit;

    // Pins pass two flip-flops; the third stage only serves edge detection.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sclk_sync_q   <= 3'h0;
            sdata_sync_q  <= 2'h0;
            strobe_sync_q <= 3'h0;
        end else begin
            sclk_sync_q   <= {sclk_sync_q[1:0], SCLK_IN};
            sdata_sync_q  <= {sdata_sync_q[0], SDATA_IN};
            strobe_sync_q <= {strobe_sync_q[1:0], LOAD_STROBE_IN};
        end
    end

    assign sclk_rise   = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2];
    assign addr        = shift_q[`ADDR_HI_POS:`ADDR_LO_POS];

    // Shift register runs regardless of any power-down state.
    // New bits enter at the bottom, so the address ends in bits 1:0.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            shift_q <= 24'h000000;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[`WORD_BITS-2:0], sdata_sync_q[1]};
        end
    end

    // Tracks whether bits have arrived since the last load.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            link_state_q <= synth_latch_pkg::LINK_IDLE;
        end else begin
            unique case (link_state_q)
                synth_latch_pkg::LINK_IDLE:
                    if (sclk_rise) link_state_q <= synth_latch_pkg::LINK_SHIFT;
                synth_latch_pkg::LINK_SHIFT:
                    if (strobe_rise) link_state_q <= synth_latch_pkg::LINK_IDLE;
            endcase
        end
    end

    // A strobe transfers only once fresh bits have arrived. A stray strobe
    // on an idle link leaves every latch and the shared gain bit as they are.
    assign load_now = strobe_rise && (link_state_q == synth_latch_pkg::LINK_SHIFT);

    // Latch transfer on strobe rise into the latch that the address picks.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            control_q   <= `CONTROL_RESET;
            feedback_q  <= `FEEDBACK_RESET;
            reference_q <= `REFERENCE_RESET;
            test_q      <= 24'h000000;
        end else if (load_now) begin
            unique case (addr)
                `ADDR_CONTROL:   control_q   <= shift_q;
                `ADDR_REFERENCE: reference_q <= shift_q;
                `ADDR_FEEDBACK:  feedback_q  <= shift_q;
                `ADDR_TEST:      test_q      <= shift_q;
            endcase
        end
    end

    // Single shared gain bit: whichever of the control and feedback latches was written last wins.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            gain_q <= 1'b0;
        end else if (load_now && addr == `ADDR_CONTROL) begin
            gain_q <= shift_q[`CTL_GAIN_POS];
        end else if (load_now && addr == `ADDR_FEEDBACK) begin
            gain_q <= shift_q[`FB_GAIN_POS];
        end
    end

    // Lock needs a run of good reference cycles; any bad one restarts it.
    assign lock_target = reference_q[`REF_PRECISION_POS] ?
                         `LOCK_COUNT_FINE : `LOCK_COUNT_COARSE;
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            good_count_q <= 3'h0;
            locked_q     <= 1'b0;
        end else if (control_q[`CTL_RESET_POS]) begin
            good_count_q <= 3'h0;
            locked_q     <= 1'b0;
        end else if (REF_TICK_IN) begin
            if (!PFD_GOOD_IN) begin
                good_count_q <= 3'h0;
                locked_q     <= 1'b0;
            end else if (good_count_q + 3'h1 >= lock_target) begin
                good_count_q <= lock_target;
                locked_q     <= 1'b1;
            end else begin
                good_count_q <= good_count_q + 3'h1;
            end
        end
    end

    // Band-select clock: toggles every 1, 2, 4 or 8 reference ticks.
    always_comb begin
        unique case (reference_q[`REF_BAND_DIV_POS +: 2])
            2'h0:    band_limit = 3'h0;
            2'h1:    band_limit = 3'h1;
            2'h2:    band_limit = 3'h3;
            default: band_limit = 3'h7;
        endcase
    end
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            band_count_q <= 3'h0;
            band_clk_q   <= 1'b0;
        end else if (control_q[`CTL_RESET_POS]) begin
            band_count_q <= 3'h0;
            band_clk_q   <= 1'b0;
        end else if (REF_TICK_IN) begin
            if (band_count_q >= band_limit) begin
                band_count_q <= 3'h0;
                band_clk_q   <= ~band_clk_q;
            end else begin
                band_count_q <= band_count_q + 3'h1;
            end
        end
    end

    // Registered decode of all settings onto the outputs.
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RF_ENABLE_OUT     <= 1'b0;
            LOCKED_OUT        <= 1'b0;
            PUMP_CURRENT_OUT  <= 3'h0;
            PUMP_TRISTATE_OUT <= 1'b0;
            PUMP_GAIN_SEL_OUT <= 1'b0;
            COUNTER_RESET_OUT <= 1'b1;
            BAND_CLK_OUT      <= 1'b0;
            TEST_MODE_OUT     <= 1'b0;
            TOTAL_DIVIDE_OUT  <= 19'h00000;
            LOOP_CFG_OUT      <= '0;
            FEEDBACK_CFG_OUT  <= '0;
            REFERENCE_CFG_OUT <= '0;
        end else begin
            RF_ENABLE_OUT <= ~control_q[`CTL_MUTE_POS] | locked_q;
            LOCKED_OUT    <= locked_q;
            PUMP_CURRENT_OUT <= gain_q ? control_q[`CTL_CUR_HI_POS +: 3]
                                       : control_q[`CTL_CUR_LO_POS +: 3];
            PUMP_TRISTATE_OUT <= control_q[`CTL_TRISTATE_POS];
            PUMP_GAIN_SEL_OUT <= gain_q;
            COUNTER_RESET_OUT <= control_q[`CTL_RESET_POS];
            BAND_CLK_OUT      <= band_clk_q;
            TEST_MODE_OUT     <= reference_q[`REF_TEST_POS] & |test_q;
            TOTAL_DIVIDE_OUT  <= 19'(PRESCALER_MOD) * 19'(feedback_q[`FB_MAIN_POS +: 13])
                                 + 19'(feedback_q[`FB_SWALLOW_POS +: 5]);
            LOOP_CFG_OUT.pump_current_lo   <= control_q[`CTL_CUR_LO_POS +: 3];
            LOOP_CFG_OUT.pump_current_hi   <= control_q[`CTL_CUR_HI_POS +: 3];
            LOOP_CFG_OUT.out_power         <= control_q[`CTL_OUT_PWR_POS +: 2];
            LOOP_CFG_OUT.core_power        <= control_q[`CTL_CORE_PWR_POS +: 2];
            LOOP_CFG_OUT.mute_until_lock   <= control_q[`CTL_MUTE_POS];
            LOOP_CFG_OUT.pump_tristate     <= control_q[`CTL_TRISTATE_POS];
            LOOP_CFG_OUT.detector_polarity <= control_q[`CTL_POLARITY_POS];
            LOOP_CFG_OUT.counter_reset     <= control_q[`CTL_RESET_POS];
            FEEDBACK_CFG_OUT.swallow_count <= feedback_q[`FB_SWALLOW_POS +: 5];
            FEEDBACK_CFG_OUT.main_count    <= feedback_q[`FB_MAIN_POS +: 13];
            FEEDBACK_CFG_OUT.output_halve_en      <= feedback_q[`FB_HALVE_POS];
            FEEDBACK_CFG_OUT.halved_prescaler_src <= feedback_q[`FB_HALVED_SRC_POS];
            REFERENCE_CFG_OUT.ref_div          <= reference_q[`REF_DIV_POS +: 14];
            REFERENCE_CFG_OUT.backlash_width   <= reference_q[`REF_BACKLASH_POS +: 2];
            REFERENCE_CFG_OUT.lock_precision   <= reference_q[`REF_PRECISION_POS];
            REFERENCE_CFG_OUT.factory_test_bit <= reference_q[`REF_TEST_POS];
            REFERENCE_CFG_OUT.band_clk_div     <= reference_q[`REF_BAND_DIV_POS +: 2];
        end
    end

endmodule // synth_serial_latch_bank

// ==== testbench/synth_serial_latch_bank_monitor.sv ====
// Concurrent checks on the ports of the serial latch bank.
// Assumes one clock domain, SYS_CLK_IN, with the asynchronous active-low reset.
module synth_serial_latch_bank_monitor #(
    parameter int PRESCALER_MOD = 8
) (
    input wire logic                           SYS_CLK_IN,
    input wire logic                           ARST_N_IN,
    input wire logic                           PFD_GOOD_IN,
    input wire logic                           REF_TICK_IN,
    input wire logic                           RF_ENABLE_OUT,
    input wire logic                           LOCKED_OUT,
    input wire logic [2:0]                     PUMP_CURRENT_OUT,
    input wire logic                           PUMP_GAIN_SEL_OUT,
    input wire logic                           COUNTER_RESET_OUT,
    input wire logic                           BAND_CLK_OUT,
    input wire logic                           TEST_MODE_OUT,
    input wire logic [18:0]                    TOTAL_DIVIDE_OUT,
    input wire synth_latch_pkg::loop_cfg_t     LOOP_CFG_OUT,
    input wire synth_latch_pkg::feedback_cfg_t FEEDBACK_CFG_OUT,
    input wire synth_latch_pkg::reference_cfg_t REFERENCE_CFG_OUT
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    // Relations are asked only once inputs have been stable, so output latency is free.
    pump_current_a: assert property ($stable({LOOP_CFG_OUT, PUMP_GAIN_SEL_OUT}) [*3] |->
        PUMP_CURRENT_OUT == (PUMP_GAIN_SEL_OUT ? LOOP_CFG_OUT.pump_current_hi
                                               : LOOP_CFG_OUT.pump_current_lo))
        else $error("pump current does not follow the gain bit");
    total_divide_a: assert property ($stable(FEEDBACK_CFG_OUT) [*3] |->
        TOTAL_DIVIDE_OUT == 19'(PRESCALER_MOD * FEEDBACK_CFG_OUT.main_count
                                + FEEDBACK_CFG_OUT.swallow_count))
        else $error("total divide is not modulus times main plus swallow");
    mute_hold_a: assert property ((LOOP_CFG_OUT.mute_until_lock && !LOCKED_OUT) [*2]
        |-> !RF_ENABLE_OUT) else $error("RF on while muted and unlocked");
    rf_unmuted_a: assert property ((!LOOP_CFG_OUT.mute_until_lock && !COUNTER_RESET_OUT)
        [*3] |-> RF_ENABLE_OUT) else $error("RF off with mute clear");
    lock_clear_a: assert property (REF_TICK_IN && !PFD_GOOD_IN |-> ##[1:2] !LOCKED_OUT)
        else $error("lock kept after a bad reference cycle");
    lock_cause_a: assert property ($rose(LOCKED_OUT) |->
        ($past(REF_TICK_IN, 1) && $past(PFD_GOOD_IN, 1))
        || ($past(REF_TICK_IN, 2) && $past(PFD_GOOD_IN, 2)))
        else $error("lock rose without a good reference tick");
    reset_hold_a: assert property (COUNTER_RESET_OUT [*3] |->
        !LOCKED_OUT && !BAND_CLK_OUT) else $error("counters run while held in reset");
    test_mode_a: assert property ((!REFERENCE_CFG_OUT.factory_test_bit) [*2]
        |-> !TEST_MODE_OUT) else $error("test mode active with test bit clear");
endmodule // synth_serial_latch_bank_monitor

bind synth_serial_latch_bank synth_serial_latch_bank_monitor #(
    .PRESCALER_MOD(PRESCALER_MOD)
) i_monitor (
    .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .PFD_GOOD_IN(PFD_GOOD_IN),
    .REF_TICK_IN(REF_TICK_IN), .RF_ENABLE_OUT(RF_ENABLE_OUT), .LOCKED_OUT(LOCKED_OUT),
    .PUMP_CURRENT_OUT(PUMP_CURRENT_OUT), .PUMP_GAIN_SEL_OUT(PUMP_GAIN_SEL_OUT),
    .COUNTER_RESET_OUT(COUNTER_RESET_OUT), .BAND_CLK_OUT(BAND_CLK_OUT),
    .TEST_MODE_OUT(TEST_MODE_OUT), .TOTAL_DIVIDE_OUT(TOTAL_DIVIDE_OUT),
    .LOOP_CFG_OUT(LOOP_CFG_OUT), .FEEDBACK_CFG_OUT(FEEDBACK_CFG_OUT),
    .REFERENCE_CFG_OUT(REFERENCE_CFG_OUT)
);

// ==== testbench/synth_host_model.sv ====
// Host side of the three-wire programming port: shifts one word per call.
// Assumes the caller stands just after a rising edge of clk_in.
module synth_host_model (
    input  wire logic clk_in,
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      load_strobe_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pins idle low before the first word.
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        load_strobe_out = 1'b0;
    end

    // Every pin level lasts at least four clocks, above the three-clock minimum.
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Reserved bits of feedback and reference words are forced to zero whatever the caller asks for.
    task automatic send_word(input logic [23:0] word);
        logic [23:0] w;
        w = word;
        if (w[1:0] == 2'h2) w[7] = 1'b0;
        if (w[1:0] == 2'h1) w[23:22] = 2'h0;
        for (int i = 23; i >= 0; i--) begin
            sdata_out = w[i];
            hold(4);
            sclk_out = 1'b1;
            hold(4);
            sclk_out = 1'b0;
        end
        sdata_out = ~sdata_out; // Released data must not look like a held bit.
        hold(4);
        load_strobe_out = 1'b1;
        hold(4);
        load_strobe_out = 1'b0;
        hold(4);
    endtask
endmodule // synth_host_model

// ==== testbench/synth_serial_latch_bank_test.sv ====
// Self-checking bench: the host model writes words, checks read decoded outputs.
// Assumes the design, its package, the monitor and the host model compile first.
`define CHK(what, expv, gotv) begin checked++; if ((gotv) !== (expv)) begin \
    n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", what, expv, gotv); \
    end end
module synth_serial_latch_bank_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic                              sys_clk, arst_n, pfd_good, ref_tick, sclk, sdata, strobe;
    logic                              rf_en, locked, tristate, gain, cnt_rst, band_clk, test_mode;
    logic [2:0]                        pump_cur;
    logic [18:0]                       total;
    synth_latch_pkg::loop_cfg_t        loop_cfg;
    synth_latch_pkg::feedback_cfg_t    fb_cfg;
    synth_latch_pkg::reference_cfg_t   ref_cfg;
    int                                n_errors = 0;
    int                                checked = 0;

    synth_serial_latch_bank #(.PRESCALER_MOD(8)) i_dut (
        .SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n), .SCLK_IN(sclk), .SDATA_IN(sdata),
        .LOAD_STROBE_IN(strobe), .PFD_GOOD_IN(pfd_good), .REF_TICK_IN(ref_tick),
        .RF_ENABLE_OUT(rf_en), .LOCKED_OUT(locked), .PUMP_CURRENT_OUT(pump_cur),
        .PUMP_TRISTATE_OUT(tristate), .PUMP_GAIN_SEL_OUT(gain), .COUNTER_RESET_OUT(cnt_rst),
        .BAND_CLK_OUT(band_clk), .TEST_MODE_OUT(test_mode), .TOTAL_DIVIDE_OUT(total),
        .LOOP_CFG_OUT(loop_cfg), .FEEDBACK_CFG_OUT(fb_cfg), .REFERENCE_CFG_OUT(ref_cfg));
    synth_host_model i_host (.clk_in(sys_clk), .sclk_out(sclk), .sdata_out(sdata),
        .load_strobe_out(strobe));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic clocks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One reference tick, spaced so lock and mute outputs have settled afterwards.
    task automatic tick(input logic good);
        ref_tick = 1'b1;
        pfd_good = good;
        clocks(1);
        ref_tick = 1'b0;
        clocks(4);
    endtask

    // A bad tick clears the count, then lock must appear on exactly the last good one.
    task automatic lock_run(input int goods);
        tick(1'b0);
        for (int n = 1; n <= goods; n++) begin
            tick(1'b1);
            `CHK("lock flag", (n == goods), locked)
            `CHK("rf enable", (n == goods), rf_en)
        end
    endtask

    // Toggles over 16 ticks do not depend on the divider's starting phase.
    task automatic band_run(input int code);
        int   edges;
        logic last;
        i_host.send_word(24'(code << 20) | 24'h000005);
        edges = 0;
        last = band_clk;
        for (int c = 0; c < 68; c++) begin
            ref_tick = (c < 64) && (c % 4 == 0);
            clocks(1);
            if (band_clk !== last) edges++;
            last = band_clk;
        end
        `CHK("band clock edges", 16 >> code, edges)
        `CHK("band divider code", code[1:0], ref_cfg.band_clk_div)
    endtask

    task automatic endtest(input string name);
        $display("test %s finished, %0d checks so far", name, checked);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A hang counts as a mismatch.
    initial begin
        repeat (50000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        pfd_good = 1'b0;
        ref_tick = 1'b0;
        repeat (5) @(posedge sys_clk);
        `CHK("reset counter flag", 1'b1, cnt_rst)
        #1 arst_n = 1'b1;
        clocks(3);
        `CHK("reset main count", 13'h000C, fb_cfg.main_count)
        `CHK("reset ref divide", 14'h0001, ref_cfg.ref_div)
        `CHK("reset total", 19'h00060, total)
        endtest("reset");
        i_host.send_word(24'h056320);
        `CHK("current lo", 3'h5, pump_cur)
        `CHK("tristate", 1'b1, tristate)
        `CHK("polarity", 1'b1, loop_cfg.detector_polarity)
        `CHK("out power", 2'h2, loop_cfg.out_power)
        `CHK("core power", 2'h1, loop_cfg.core_power)
        `CHK("counter reset", 1'b0, cnt_rst)
        `CHK("rf unmuted", 1'b1, rf_en)
        i_host.send_word(24'h056C20);
        `CHK("current hi", 3'h2, pump_cur)
        `CHK("polarity neg", 1'b0, loop_cfg.detector_polarity)
        `CHK("rf muted", 1'b0, rf_en)
        `CHK("tristate off", 1'b0, tristate)
        `CHK("tristate field", 1'b0, loop_cfg.pump_tristate)
        `CHK("current hi field", 3'h2, loop_cfg.pump_current_hi)
        `CHK("mute field", 1'b1, loop_cfg.mute_until_lock)
        endtest("control");
        i_host.send_word(24'hDFFFFE);
        `CHK("gain from feedback", 1'b0, gain)
        `CHK("current after gain", 3'h5, pump_cur)
        `CHK("swallow max", 5'h1F, fb_cfg.swallow_count)
        `CHK("main max", 13'h1FFF, fb_cfg.main_count)
        `CHK("halve on", 1'b1, fb_cfg.output_halve_en)
        `CHK("halved src", 1'b1, fb_cfg.halved_prescaler_src)
        `CHK("total max", 19'h10017, total)
        `CHK("control kept", 1'b1, loop_cfg.mute_until_lock)
        i_host.send_word(24'h200302);
        `CHK("main min", 13'h0003, fb_cfg.main_count)
        `CHK("total min", 19'h00018, total)
        `CHK("halve off", 1'b0, fb_cfg.output_halve_en)
        `CHK("fundamental src", 1'b0, fb_cfg.halved_prescaler_src)
        `CHK("gain set again", 1'b1, gain)
        endtest("feedback");
        i_host.send_word(24'hC7FFFD);
        `CHK("ref divide max", 14'h3FFF, ref_cfg.ref_div)
        `CHK("backlash", 2'h3, ref_cfg.backlash_width)
        `CHK("precision", 1'b1, ref_cfg.lock_precision)
        `CHK("test bit clear", 1'b0, ref_cfg.factory_test_bit)
        `CHK("feedback kept", 13'h0003, fb_cfg.main_count)
        i_host.send_word(24'hFFFFFF);
        `CHK("test mode off", 1'b0, test_mode)
        `CHK("ref after test", 14'h3FFF, ref_cfg.ref_div)
        endtest("reference");
        lock_run(5);
        tick(1'b0);
        `CHK("lock lost", 1'b0, locked)
        `CHK("rf muted again", 1'b0, rf_en)
        i_host.send_word(24'h000005);
        lock_run(3);
        endtest("lock");
        pfd_good = 1'b1;
        for (int code = 0; code < 4; code++) band_run(code);
        endtest("band clock");
        i_host.send_word(24'h000010);
        `CHK("counter reset on", 1'b1, cnt_rst)
        `CHK("lock cleared", 1'b0, locked)
        `CHK("reset field", 1'b1, loop_cfg.counter_reset)
        endtest("counter reset");
        conclude();
    end
endmodule // synth_serial_latch_bank_test
